// >>> design/ptd_prio_map.sv
// ptd_prio_map: user priority and traffic class stage for arrivals.
// assumes configuration is stable while frames arrive.
`timescale 1ns/1ps
`default_nettype none

module ptd_prio_map
  import ptd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        in_valid_i,
  input  wire ptd_frame_t  in_frame_i,
  input  wire ptd_cfg_t    cfg_i,
  output var  logic        map_valid_o,
  output var  ptd_frame_t  map_frame_o,
  output var  logic [2:0]  map_uprio_o,
  output var  logic [2:0]  map_tc_o
);

  logic       valid_reg;
  logic       valid_next;
  ptd_frame_t frame_reg;
  ptd_frame_t frame_next;
  logic [2:0] uprio_reg;
  logic [2:0] uprio_next;
  logic [2:0] tc_reg;
  logic [2:0] tc_next;

  // the same path serves unicast and multicast alike
  always_comb
  begin
    valid_next = in_valid_i;
    frame_next = in_frame_i;
    if (cfg_i.trusted && in_frame_i.cos_ok)
    begin
      uprio_next = in_frame_i.cos;
    end
    else if (cfg_i.policy_en)
    begin
      uprio_next = cfg_i.policy_map[in_frame_i.cos];
    end
    else
    begin
      uprio_next = cfg_i.default_prio;
    end
    tc_next = ptd_tc_of(uprio_next);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      valid_reg <= 1'b0;
      frame_reg <= '0;
      uprio_reg <= PRIO_RST;
      tc_reg    <= PRIO_RST;
    end
    else
    begin
      valid_reg <= valid_next;
      frame_reg <= frame_next;
      uprio_reg <= uprio_next;
      tc_reg    <= tc_next;
    end
  end

  assign map_valid_o = valid_reg;
  assign map_frame_o = frame_reg;
  assign map_uprio_o = uprio_reg;
  assign map_tc_o    = tc_reg;

endmodule // ptd_prio_map

`default_nettype wire

// >>> design/ptd_tail_drop.sv
// ptd_tail_drop: per-port queueing and tail-drop admission.
// assumes the egress scheduler asks for one queue head at a time and the
// ingress side presents at most one frame per cycle.
`timescale 1ns/1ps
`default_nettype none

module ptd_tail_drop
  import ptd_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               in_valid_i,
  input  wire ptd_frame_t         in_frame_i,
  input  wire ptd_cfg_t           cfg_i,
  input  wire logic               deq_valid_i,
  input  wire logic [QIDX_W-1:0]  deq_queue_i,
  output var  logic               out_valid_o,
  output var  ptd_desc_t          out_desc_o,
  output var  logic               accept_o,
  output var  logic               drop_o,
  output var  logic [2:0]         drop_cause_o,
  output var  logic [NUM_Q-1:0]   q_nonempty_o,
  output var  logic [OCC_W-1:0]   port_occ_o
);

  logic       map_valid;
  ptd_frame_t map_frame;
  logic [2:0] map_uprio;
  logic [2:0] map_tc;

  ptd_prio_map u_map (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (in_valid_i),
    .in_frame_i  (in_frame_i),
    .cfg_i       (cfg_i),
    .map_valid_o (map_valid),
    .map_frame_o (map_frame),
    .map_uprio_o (map_uprio),
    .map_tc_o    (map_tc)
  );

  // descriptor store: Q_DEPTH slots per queue, addressed {queue, slot}
  ptd_desc_t q_mem [NUM_Q*Q_DEPTH];

  logic [QPTR_W-1:0] head_reg [NUM_Q];
  logic [QPTR_W-1:0] head_next [NUM_Q];
  logic [QPTR_W-1:0] tail_reg [NUM_Q];
  logic [QPTR_W-1:0] tail_next [NUM_Q];
  logic [QCNT_W-1:0] cnt_reg [NUM_Q];
  logic [QCNT_W-1:0] cnt_next [NUM_Q];

  logic [OCC_W-1:0] port_occ_reg;
  logic [OCC_W-1:0] port_occ_next;
  logic [OCC_W-1:0] prio_occ_reg [NUM_TC];
  logic [OCC_W-1:0] prio_occ_next [NUM_TC];

  logic             out_valid_reg;
  logic             out_valid_next;
  ptd_desc_t        out_desc_reg;
  ptd_desc_t        out_desc_next;
  logic             accept_reg;
  logic             accept_next;
  logic             drop_reg;
  logic             drop_next;
  logic [2:0]       cause_reg;
  logic [2:0]       cause_next;
  logic [NUM_Q-1:0] nonempty_reg;
  logic [NUM_Q-1:0] nonempty_next;

  logic [QIDX_W-1:0]           enq_q;
  logic                        enq_do;
  logic                        deq_do;
  logic [QIDX_W+QPTR_W-1:0]    wr_addr;
  ptd_desc_t                   wr_desc;
  ptd_desc_t                   head_desc;
  logic [OCC_W:0]              port_sum;
  logic [OCC_W:0]              prio_sum;
  logic [OCC_W-1:0]            prio_lim;
  logic [2:0]                  cause;

  // sum one bit wider than the counter, so a frame landing on a nearly
  // full counter still compares as over the limit instead of wrapping
  function automatic logic [OCC_W:0] occ_plus(
    input logic [OCC_W-1:0]  occ,
    input logic [CELL_W-1:0] cells
  );
    occ_plus = {1'b0, occ} + (OCC_W+1)'(cells);
  endfunction

  // strict compare: a frame that exactly fills its share is admitted
  function automatic logic over_lim(
    input logic [OCC_W:0]   sum,
    input logic [OCC_W-1:0] lim
  );
    over_lim = sum > {1'b0, lim};
  endfunction

  function automatic logic [OCC_W-1:0] occ_minus(
    input logic [OCC_W-1:0]  occ,
    input logic [CELL_W-1:0] cells
  );
    occ_minus = occ - OCC_W'(cells);
  endfunction

  function automatic logic q_hit(
    input logic [QIDX_W-1:0] idx,
    input int                q
  );
    q_hit = idx == QIDX_W'(q);
  endfunction

  // admission decision on the mapped arrival
  always_comb
  begin
    enq_q    = {map_frame.mcast, map_tc};
    port_sum = occ_plus(port_occ_reg, map_frame.cells);
    prio_sum = occ_plus(prio_occ_reg[map_uprio], map_frame.cells);
    // percentages summing above 100 would overbook the port; the port
    // check below still bounds the total in that case
    prio_lim = ptd_prio_limit(cfg_i.port_limit,
                              cfg_i.prio_pct[map_uprio]);
    cause = 3'h0;
    cause[CAUSE_PORT]  = over_lim(port_sum, cfg_i.port_limit);
    cause[CAUSE_PRIO]  = map_frame.mcast
                       && over_lim(prio_sum, prio_lim);
    cause[CAUSE_QFULL] = cnt_reg[enq_q] == QCNT_FULL;
    enq_do = map_valid && (cause == 3'h0);
    deq_do = deq_valid_i && (cnt_reg[deq_queue_i] != QCNT_RST);
    head_desc = q_mem[{deq_queue_i, head_reg[deq_queue_i]}];
    wr_addr   = {enq_q, tail_reg[enq_q]};
    wr_desc.mcast = map_frame.mcast;
    wr_desc.uprio = map_uprio;
    wr_desc.vid   = map_frame.vid;
    wr_desc.cells = map_frame.cells;
  end

  // queue pointers and counts; an enqueue and a dequeue on the same
  // queue in one cycle leave the count unchanged
  always_comb
  begin
    for (int q = 0; q < NUM_Q; q++)
    begin
      head_next[q] = head_reg[q];
      tail_next[q] = tail_reg[q];
      cnt_next[q]  = cnt_reg[q];
      if (enq_do && q_hit(enq_q, q))
      begin
        tail_next[q] = tail_reg[q] + 3'h1;
        cnt_next[q]  = cnt_next[q] + 4'h1;
      end
      if (deq_do && q_hit(deq_queue_i, q))
      begin
        head_next[q] = head_reg[q] + 3'h1;
        cnt_next[q]  = cnt_next[q] - 4'h1;
      end
      nonempty_next[q] = cnt_next[q] != QCNT_RST;
    end
  end

  // buffer occupancy, port total and multicast per priority
  always_comb
  begin
    port_occ_next = port_occ_reg;
    if (enq_do)
    begin
      port_occ_next = port_occ_next + OCC_W'(map_frame.cells);
    end
    if (deq_do)
    begin
      port_occ_next = occ_minus(port_occ_next, head_desc.cells);
    end
    for (int p = 0; p < NUM_TC; p++)
    begin
      prio_occ_next[p] = prio_occ_reg[p];
      if (enq_do && map_frame.mcast && (map_uprio == 3'(p)))
      begin
        prio_occ_next[p] = prio_occ_next[p]
                         + OCC_W'(map_frame.cells);
      end
      if (deq_do && head_desc.mcast && (head_desc.uprio == 3'(p)))
      begin
        prio_occ_next[p] = occ_minus(prio_occ_next[p],
                                     head_desc.cells);
      end
    end
  end

  // egress result with header rewrite
  always_comb
  begin
    out_valid_next = deq_do;
    out_desc_next  = out_desc_reg;
    if (deq_do)
    begin
      out_desc_next = head_desc;
      if (cfg_i.vid_rw_en)
      begin
        out_desc_next.vid = cfg_i.vid_rw;
      end
    end
    accept_next = enq_do;
    drop_next   = map_valid && !enq_do;
    cause_next  = map_valid ? cause : 3'h0;
  end

  // the store has no reset: a slot is only read after it was written
  always_ff @(posedge clk_i)
  begin
    if (enq_do)
    begin
      q_mem[wr_addr] <= wr_desc;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int q = 0; q < NUM_Q; q++)
      begin
        head_reg[q] <= PTR_RST;
        tail_reg[q] <= PTR_RST;
        cnt_reg[q]  <= QCNT_RST;
      end
      nonempty_reg <= '0;
    end
    else
    begin
      for (int q = 0; q < NUM_Q; q++)
      begin
        head_reg[q] <= head_next[q];
        tail_reg[q] <= tail_next[q];
        cnt_reg[q]  <= cnt_next[q];
      end
      nonempty_reg <= nonempty_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      port_occ_reg <= OCC_RST;
      for (int p = 0; p < NUM_TC; p++)
      begin
        prio_occ_reg[p] <= OCC_RST;
      end
    end
    else
    begin
      port_occ_reg <= port_occ_next;
      for (int p = 0; p < NUM_TC; p++)
      begin
        prio_occ_reg[p] <= prio_occ_next[p];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_reg <= 1'b0;
      out_desc_reg  <= '0;
      accept_reg    <= 1'b0;
      drop_reg      <= 1'b0;
      cause_reg     <= 3'h0;
    end
    else
    begin
      out_valid_reg <= out_valid_next;
      out_desc_reg  <= out_desc_next;
      accept_reg    <= accept_next;
      drop_reg      <= drop_next;
      cause_reg     <= cause_next;
    end
  end

  assign out_valid_o  = out_valid_reg;
  assign out_desc_o   = out_desc_reg;
  assign accept_o     = accept_reg;
  assign drop_o       = drop_reg;
  assign drop_cause_o = cause_reg;
  assign q_nonempty_o = nonempty_reg;
  assign port_occ_o   = port_occ_reg;

endmodule // ptd_tail_drop

`default_nettype wire

// >>> include/ptd_pkg.sv
// ptd_pkg: shared widths, reset values, carriers and helpers for the
// priority tail-drop admission block.
// assumes one switch clock domain; frame sizes are given in buffer cells.
package ptd_pkg;

  localparam int NUM_TC      = 8;
  localparam int NUM_Q       = 16;
  localparam int Q_DEPTH     = 8;
  localparam int QPTR_W      = 3;
  localparam int QCNT_W      = 4;
  localparam int QIDX_W      = 4;
  localparam int CELL_W      = 6;
  localparam int OCC_W       = 10;
  localparam int PCT_W       = 7;
  localparam int PROD_W      = 17;

  localparam logic [OCC_W-1:0]  OCC_RST    = 10'h000;
  localparam logic [QPTR_W-1:0] PTR_RST    = 3'h0;
  localparam logic [QCNT_W-1:0] QCNT_RST   = 4'h0;
  localparam logic [QCNT_W-1:0] QCNT_FULL  = 4'h8;
  localparam logic [PROD_W-1:0] PCT_DIV    = 17'h00064;
  localparam logic [2:0]        PRIO_RST   = 3'h0;

  // drop cause bits
  localparam int CAUSE_PORT  = 0;
  localparam int CAUSE_PRIO  = 1;
  localparam int CAUSE_QFULL = 2;

  typedef struct packed {
    logic              mcast;
    logic              cos_ok;
    logic [2:0]        cos;
    logic [11:0]       vid;
    logic [CELL_W-1:0] cells;
  } ptd_frame_t;

  typedef struct packed {
    logic                          trusted;
    logic                          policy_en;
    logic [2:0]                    default_prio;
    logic [NUM_TC-1:0][2:0]        policy_map;
    logic [OCC_W-1:0]              port_limit;
    logic [NUM_TC-1:0][PCT_W-1:0]  prio_pct;
    logic                          vid_rw_en;
    logic [11:0]                   vid_rw;
  } ptd_cfg_t;

  typedef struct packed {
    logic              mcast;
    logic [2:0]        uprio;
    logic [11:0]       vid;
    logic [CELL_W-1:0] cells;
  } ptd_desc_t;

  // standard eight-class priority to traffic class table
  function automatic logic [2:0] ptd_tc_of(input logic [2:0] up);
    unique case (up)
      3'h0:    ptd_tc_of = 3'h1;
      3'h1:    ptd_tc_of = 3'h0;
      default: ptd_tc_of = up;
    endcase
  endfunction

  // buffer share of one priority: port share scaled by its percentage
  function automatic logic [OCC_W-1:0] ptd_prio_limit(
    input logic [OCC_W-1:0] port_lim,
    input logic [PCT_W-1:0] pct
  );
    logic [PROD_W-1:0] prod;
    prod = PROD_W'(port_lim) * PROD_W'(pct);
    ptd_prio_limit = OCC_W'(prod / PCT_DIV);
  endfunction

endpackage

// >>> verification/ptd_sched_model.sv
// ptd_sched_model: egress scheduler that pulses one dequeue per request.
// assumes requests come one at a time; slow_i adds three idle cycles.
`timescale 1ns/1ps
`default_nettype none

module ptd_sched_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic [3:0] req_q_i,
  input  wire logic       slow_i,
  output var  logic       deq_valid_o,
  output var  logic [3:0] deq_queue_o
);
  logic       pend_reg;
  logic [1:0] cnt_reg;
  logic [3:0] q_reg;

  // index is only meaningful with the pulse; otherwise show its inverse
  assign deq_queue_o = deq_valid_o ? q_reg : ~q_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      pend_reg    <= 1'b0;
      cnt_reg     <= 2'h0;
      q_reg       <= 4'h0;
      deq_valid_o <= 1'b0;
    end
    else
    begin
      deq_valid_o <= 1'b0;
      if (req_i)
      begin
        pend_reg <= 1'b1;
        cnt_reg  <= slow_i ? 2'h3 : 2'h0;
        q_reg    <= req_q_i;
      end
      else if (pend_reg && cnt_reg == 2'h0)
      begin
        deq_valid_o <= 1'b1;
        pend_reg    <= 1'b0;
      end
      else if (pend_reg)
        cnt_reg <= cnt_reg - 2'h1;
    end
endmodule // ptd_sched_model

`default_nettype wire

// >>> verification/ptd_tail_drop_props.sv
// ptd_tail_drop_props: port-level checks of the admission block.
// assumes it is bound to ptd_tail_drop and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module ptd_tail_drop_props
  import ptd_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              in_valid_i,
  input wire ptd_frame_t        in_frame_i,
  input wire ptd_cfg_t          cfg_i,
  input wire logic              deq_valid_i,
  input wire logic [QIDX_W-1:0] deq_queue_i,
  input wire logic              out_valid_o,
  input wire ptd_desc_t         out_desc_o,
  input wire logic              accept_o,
  input wire logic              drop_o,
  input wire logic [2:0]        drop_cause_o,
  input wire logic [NUM_Q-1:0]  q_nonempty_o,
  input wire logic [OCC_W-1:0]  port_occ_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ans; in_valid_i |-> ##2 (accept_o ^ drop_o); endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_idle;
    !in_valid_i |-> ##2 !(accept_o || drop_o) && drop_cause_o == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_cause;
    (accept_o || drop_o) |-> ((drop_cause_o != 3'h0) == drop_o);
  endproperty
  a_cause: assert property (p_cause) else $error("bad cause");
  property p_up;
    accept_o && !out_valid_o |-> port_occ_o > $past(port_occ_o);
  endproperty
  a_up: assert property (p_up) else $error("occ not raised");
  property p_dn;
    out_valid_o && !accept_o |->
      port_occ_o == $past(port_occ_o) - OCC_W'(out_desc_o.cells);
  endproperty
  a_dn: assert property (p_dn) else $error("occ not lowered");
  property p_deq;
    deq_valid_i |=> out_valid_o == $past(q_nonempty_o[deq_queue_i]);
  endproperty
  a_deq: assert property (p_deq) else $error("bad dequeue");
  property p_lim; port_occ_o <= cfg_i.port_limit; endproperty
  a_lim: assert property (p_lim) else $error("port over limit");
  property p_vid;
    out_valid_o && cfg_i.vid_rw_en |-> out_desc_o.vid == cfg_i.vid_rw;
  endproperty
  a_vid: assert property (p_vid) else $error("vid not rewritten");
endmodule // ptd_tail_drop_props

`default_nettype wire

// >>> verification/test_ptd_tail_drop.sv
// test_ptd_tail_drop: self-checking bench for the admission block.
// assumes ptd_sched_model plays egress; ingress is driven here.
`timescale 1ns/1ps
`default_nettype none

module test_ptd_tail_drop
  import ptd_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        in_valid = 1'b0;
  ptd_frame_t  in_frame = '0;
  ptd_cfg_t    cfg = '0;
  logic        req = 1'b0;
  logic [3:0]  req_q = 4'h0;
  logic        slow = 1'b0;
  logic        deq_valid, out_valid, accept, drop;
  logic [3:0]  deq_queue;
  logic [2:0]  cause;
  logic [15:0] q_ne;
  logic [9:0]  occ;
  ptd_desc_t   desc;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #25 clk_i = ~clk_i;

  ptd_tail_drop u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .in_valid_i(in_valid), .in_frame_i(in_frame), .cfg_i(cfg),
    .deq_valid_i(deq_valid), .deq_queue_i(deq_queue),
    .out_valid_o(out_valid), .out_desc_o(desc), .accept_o(accept),
    .drop_o(drop), .drop_cause_o(cause), .q_nonempty_o(q_ne),
    .port_occ_o(occ));
  ptd_sched_model u_sched (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
    .req_q_i(req_q), .slow_i(slow), .deq_valid_o(deq_valid),
    .deq_queue_o(deq_queue));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic ptd_frame_t fr(logic m, logic [2:0] c, logic [5:0] n);
    return '{m, 1'b1, c, 12'h123, n};
  endfunction
  function automatic ptd_desc_t dsc(logic m, logic [2:0] u, logic [5:0] n);
    return '{m, u, 12'hABC, n};
  endfunction
  // eight-class table: priorities 0 and 1 swap classes
  function automatic logic [3:0] qi(logic m, logic [2:0] u);
    return {m, (u == 3'h0) ? 3'h1 : (u == 3'h1) ? 3'h0 : u};
  endfunction

  task automatic send(ptd_frame_t f, logic ok, logic [2:0] c);
    @(posedge clk_i) in_valid <= 1'b1;
    in_frame <= f;
    @(posedge clk_i) in_valid <= 1'b0;
    @(posedge clk_i);
    #1 chk(32'({accept, drop, cause}), 32'({ok, !ok, c}));
  endtask

  task automatic deq(logic [3:0] q, ptd_desc_t e, logic v);
    logic seen;
    seen = 1'b0;
    @(posedge clk_i) req <= 1'b1;
    req_q <= q;
    slow <= ~slow;
    @(posedge clk_i) req <= 1'b0;
    repeat (8)
    begin
      @(posedge clk_i);
      #1 seen = seen | out_valid;
      if (seen)
        break;
    end
    chk(32'(seen), 32'(v));
    if (v)
      chk(32'(desc), 32'(e));
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    cfg.trusted <= 1'b1;
    cfg.default_prio <= 3'h3;
    for (int i = 0; i < 8; i++)
      cfg.policy_map[i] <= 3'(7 - i);
    // eight shares of 12 stay within the 100 total
    for (int i = 0; i < 8; i++)
      cfg.prio_pct[i] <= 7'h0C;
    cfg.port_limit <= 10'h3E8;
    cfg.vid_rw_en <= 1'b1;
    cfg.vid_rw <= 12'hABC;
    rst_n_i <= 1'b1;
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 8; c++)
      begin
        send(fr(1'(m), 3'(c), 6'h01), 1'b1, 3'h0);
        chk(32'(q_ne[qi(1'(m), 3'(c))]), 32'h1);
        deq(qi(1'(m), 3'(c)), dsc(1'(m), 3'(c), 6'h01), 1'b1);
      end
    @(posedge clk_i) cfg.trusted <= 1'b0;
    send(fr(1'b0, 3'h5, 6'h02), 1'b1, 3'h0);
    deq(qi(1'b0, 3'h3), dsc(1'b0, 3'h3, 6'h02), 1'b1);
    @(posedge clk_i) cfg.policy_en <= 1'b1;
    send(fr(1'b1, 3'h5, 6'h02), 1'b1, 3'h0);
    deq(qi(1'b1, 3'h2), dsc(1'b1, 3'h2, 6'h02), 1'b1);
    @(posedge clk_i) cfg.trusted <= 1'b1;
    for (int i = 1; i < 9; i++)
      send(fr(1'b0, 3'h4, 6'(i)), 1'b1, 3'h0);
    send(fr(1'b0, 3'h4, 6'h01), 1'b0, 3'h4);
    chk(32'(occ), 32'h24);
    for (int i = 1; i < 9; i++)
      deq(4'h4, dsc(1'b0, 3'h4, 6'(i)), 1'b1);
    chk(32'(q_ne), 32'h0);
    deq(4'h4, dsc(1'b0, 3'h4, 6'h01), 1'b0);
    @(posedge clk_i) cfg.port_limit <= 10'h014;
    send(fr(1'b0, 3'h6, 6'h0F), 1'b1, 3'h0);
    send(fr(1'b0, 3'h6, 6'h06), 1'b0, 3'h1);
    deq(4'h6, dsc(1'b0, 3'h6, 6'h0F), 1'b1);
    send(fr(1'b0, 3'h6, 6'h06), 1'b1, 3'h0);
    deq(4'h6, dsc(1'b0, 3'h6, 6'h06), 1'b1);
    @(posedge clk_i) cfg.port_limit <= 10'h064;
    cfg.prio_pct[2] <= 7'h0A;
    send(fr(1'b1, 3'h2, 6'h0A), 1'b1, 3'h0);
    send(fr(1'b1, 3'h2, 6'h01), 1'b0, 3'h2);
    send(fr(1'b0, 3'h2, 6'h14), 1'b1, 3'h0);
    send(fr(1'b1, 3'h3, 6'h0C), 1'b1, 3'h0);
    send(fr(1'b1, 3'h3, 6'h01), 1'b0, 3'h2);
    deq(4'hA, dsc(1'b1, 3'h2, 6'h0A), 1'b1);
    deq(4'h2, dsc(1'b0, 3'h2, 6'h14), 1'b1);
    deq(4'hB, dsc(1'b1, 3'h3, 6'h0C), 1'b1);
    send(fr(1'b1, 3'h2, 6'h0A), 1'b1, 3'h0);
    // trusted port, frame without a tag: policy table, vid kept as sent
    @(posedge clk_i) cfg.vid_rw_en <= 1'b0;
    send(ptd_frame_t'{1'b0, 1'b0, 3'h6, 12'h123, 6'h03}, 1'b1, 3'h0);
    deq(4'h0, ptd_desc_t'{1'b0, 3'h1, 12'h123, 6'h03}, 1'b1);
    end_of_test();
  end
endmodule // test_ptd_tail_drop

bind ptd_tail_drop ptd_tail_drop_props u_props (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .in_valid_i(in_valid_i), .in_frame_i(in_frame_i),
  .cfg_i(cfg_i), .deq_valid_i(deq_valid_i), .deq_queue_i(deq_queue_i),
  .out_valid_o(out_valid_o), .out_desc_o(out_desc_o),
  .accept_o(accept_o), .drop_o(drop_o), .drop_cause_o(drop_cause_o),
  .q_nonempty_o(q_nonempty_o), .port_occ_o(port_occ_o));

`default_nettype wire
